// ### inc/sgim_pkg.sv
// package of constants for the supply and pin interrupt mask bank
package sgim_pkg;

    // ***************************************************
    // bus geometry
    // ***************************************************
    localparam int unsigned SGIM_AW = 16; // register address width
    localparam int unsigned SGIM_DW = 16; // register data width

    // ***************************************************
    // register offsets
    // ***************************************************
    localparam logic [15:0] SGIM_SUP_MASK_ADDR = 16'h401C; // supply_event_irq_mask
    localparam logic [15:0] SGIM_PIN_MASK_ADDR = 16'h401D; // pin_event_irq_mask
    localparam logic [15:0] SGIM_SUP_STAT_ADDR = 16'h4040; // sticky supply events, ro
    localparam logic [15:0] SGIM_PIN_STAT_ADDR = 16'h4041; // sticky pin events, ro
    localparam logic [15:0] SGIM_SUP_CLR_ADDR = 16'h4042; // supply clear, wo
    localparam logic [15:0] SGIM_PIN_CLR_ADDR = 16'h4043; // pin clear, wo
    localparam logic [15:0] SGIM_SUP_EN_ADDR = 16'h4044; // supply enable, rw
    localparam logic [15:0] SGIM_PIN_EN_ADDR = 16'h4045; // pin enable, rw

    // ***************************************************
    // supply register field positions
    // ***************************************************
    localparam int unsigned BUCK2_OVERCURRENT_MASK_BIT = 9;
    localparam int unsigned BUCK1_OVERCURRENT_MASK_BIT = 8;
    localparam int unsigned CRYSTAL_STARTUP_MASK_BIT = 7;
    localparam int unsigned BUCK4_UNDERVOLTAGE_MASK_BIT = 3;
    localparam int unsigned BUCK3_UNDERVOLTAGE_MASK_BIT = 2;
    localparam int unsigned BUCK2_UNDERVOLTAGE_MASK_BIT = 1;
    localparam int unsigned BUCK1_UNDERVOLTAGE_MASK_BIT = 0;

    // ***************************************************
    // pin register field positions
    // ***************************************************
    localparam int unsigned PIN_EVENT_COUNT = 12; // pin n masked by bit n-1
    localparam int unsigned PIN1_EVENT_MASK_BIT = 0;
    localparam int unsigned PIN12_EVENT_MASK_BIT = 11;

    // ***************************************************
    // implemented bits and reset values
    // ***************************************************
    localparam logic [15:0] SGIM_SUP_IMPL = 16'h038F; // bits 9,8,7,3..0
    localparam logic [15:0] SGIM_PIN_IMPL = 16'h0FFF; // bits 11..0
    localparam logic [15:0] SGIM_SUP_MASK_RST = SGIM_SUP_IMPL; // all blocked
    localparam logic [15:0] SGIM_PIN_MASK_RST = SGIM_PIN_IMPL; // all blocked
    localparam logic [15:0] SGIM_SUP_EN_RST = SGIM_SUP_IMPL; // enables open
    localparam logic [15:0] SGIM_PIN_EN_RST = SGIM_PIN_IMPL; // enables open
    localparam logic [15:0] SGIM_ZERO = 16'h0000; // read value of holes

endpackage

// ### inc/sgim_evt_if.sv
// interface carrying one bank of event sources, clears and sticky flags
`timescale 1ns/100ps
`default_nettype none

interface sgim_evt_if;
    logic [15:0] raw; // live status of each source
    logic [15:0] clr; // one-cycle clear pulses, one per bit
    logic [15:0] sticky; // latched events

    // the bank owns the sticky flags
    modport bank (
        input raw,
        input clr,
        output sticky
    );
    // the register file feeds sources and clears
    modport ctl (
        output raw,
        output clr,
        input sticky
    );
endinterface

`default_nettype wire

// ### rtl/sgim_sticky.sv
// sticky event flag bank with per-bit rising edge capture
`timescale 1ns/100ps
`default_nettype none

module sgim_sticky #(
    parameter logic [15:0] IMPL = 16'hFFFF // bits that exist
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    sgim_evt_if.bank evt
);
    import sgim_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    logic [15:0] prev_ff; // last seen source level
    logic [15:0] sticky_ff; // latched flags
    logic [15:0] nxt_prev;
    logic [15:0] nxt_sticky;

    // per-bit next values; an edge in the clear cycle still lands
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_bit
            always_comb begin
                nxt_prev[g] = evt.raw[g] & IMPL[g];
                // set wins over clear so no event is lost
                nxt_sticky[g] = IMPL[g] & ((evt.raw[g] & ~prev_ff[g]) |
                                (sticky_ff[g] & ~evt.clr[g]));
            end
        end
    endgenerate

    // registers only
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            prev_ff <= SGIM_ZERO;
            sticky_ff <= SGIM_ZERO;
        end else begin
            prev_ff <= nxt_prev;
            sticky_ff <= nxt_sticky;
        end
    end

    assign evt.sticky = sticky_ff;
endmodule

`default_nettype wire

// ### rtl/sgim_top.sv
// supply and pin event interrupt mask bank with register port
//
// Operation
// - mask 0 passes event, 1 blocks it
// - all implemented mask bits reset to one
// - supply mask at 401C, bits 9,8,7,3..0
// - pin mask at 401D, bits 11..0
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module sgim_top (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [sgim_pkg::SGIM_AW-1:0] reg_addr_i,
    input wire logic [sgim_pkg::SGIM_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sgim_pkg::SGIM_DW-1:0] reg_rdata_o,
    input wire logic [15:0] supply_event_i,
    input wire logic [sgim_pkg::PIN_EVENT_COUNT-1:0] pin_event_i,
    output logic irq_o
);
    import sgim_pkg::*;

    // ***************************************************
    // decode helpers
    // ***************************************************

    // true when the address equals the given offset; the strobe is checked by the caller
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // one bank's contribution to the request line
    function automatic logic pend(input logic [15:0] st, input logic [15:0] msk,
                                  input logic [15:0] en);
        pend = |(st & ~msk & en);
    endfunction

    // ***************************************************
    // event banks
    // ***************************************************
    sgim_evt_if sup_if (); // supply sources
    sgim_evt_if pin_if (); // pin sources

    // sources come from same-clock status logic, so no synchroniser
    assign sup_if.raw = supply_event_i & SGIM_SUP_IMPL;
    assign pin_if.raw = {{(16-PIN_EVENT_COUNT){1'b0}}, pin_event_i};

    sgim_sticky #(
        .IMPL(SGIM_SUP_IMPL)
    ) u_sup_bank (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .evt(sup_if.bank)
    );

    sgim_sticky #(
        .IMPL(SGIM_PIN_IMPL)
    ) u_pin_bank (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .evt(pin_if.bank)
    );

    // ***************************************************
    // register state
    // ***************************************************
    logic [15:0] sup_mask_ff; // supply_event_irq_mask
    logic [15:0] pin_mask_ff; // pin_event_irq_mask
    logic [15:0] sup_en_ff; // supply enable
    logic [15:0] pin_en_ff; // pin enable
    logic [15:0] sup_clr_ff; // supply clear pulse
    logic [15:0] pin_clr_ff; // pin clear pulse
    logic [15:0] rdata_ff; // read answer
    logic irq_ff; // request line
    logic [15:0] nxt_sup_mask;
    logic [15:0] nxt_pin_mask;
    logic [15:0] nxt_sup_en;
    logic [15:0] nxt_pin_en;
    logic [15:0] nxt_sup_clr;
    logic [15:0] nxt_pin_clr;
    logic [15:0] nxt_rdata;
    logic nxt_irq;

    // clear pulses reach the banks straight from flops
    assign sup_if.clr = sup_clr_ff;
    assign pin_if.clr = pin_clr_ff;

    // ***************************************************
    // write path
    // ***************************************************

    // writes keep only implemented bits, so holes stay zero
    always_comb begin
        nxt_sup_mask = sup_mask_ff;
        nxt_pin_mask = pin_mask_ff;
        nxt_sup_en = sup_en_ff;
        nxt_pin_en = pin_en_ff;
        nxt_sup_clr = SGIM_ZERO; // clears last one cycle
        nxt_pin_clr = SGIM_ZERO;
        if (reg_wr_i) begin
            // supply mask layout is fixed by the implemented set
            if (hit(reg_addr_i, SGIM_SUP_MASK_ADDR)) begin
                nxt_sup_mask = reg_wdata_i & SGIM_SUP_IMPL;
            end
            // pin n sits at bit n-1
            if (hit(reg_addr_i, SGIM_PIN_MASK_ADDR)) begin
                nxt_pin_mask = reg_wdata_i & SGIM_PIN_IMPL;
            end
            if (hit(reg_addr_i, SGIM_SUP_EN_ADDR)) begin
                nxt_sup_en = reg_wdata_i & SGIM_SUP_IMPL;
            end
            if (hit(reg_addr_i, SGIM_PIN_EN_ADDR)) begin
                nxt_pin_en = reg_wdata_i & SGIM_PIN_IMPL;
            end
            // write one to clear; the bank lets a new edge win
            if (hit(reg_addr_i, SGIM_SUP_CLR_ADDR)) begin
                nxt_sup_clr = reg_wdata_i & SGIM_SUP_IMPL;
            end
            if (hit(reg_addr_i, SGIM_PIN_CLR_ADDR)) begin
                nxt_pin_clr = reg_wdata_i & SGIM_PIN_IMPL;
            end
        end
    end

    // ***************************************************
    // read path
    // ***************************************************

    // answer stands in the cycle after the strobe only
    always_comb begin
        nxt_rdata = SGIM_ZERO;
        if (reg_rd_i) begin
            case (reg_addr_i)
                SGIM_SUP_MASK_ADDR: begin
                    nxt_rdata = sup_mask_ff;
                end
                SGIM_PIN_MASK_ADDR: begin
                    nxt_rdata = pin_mask_ff;
                end
                SGIM_SUP_STAT_ADDR: begin
                    nxt_rdata = sup_if.sticky;
                end
                SGIM_PIN_STAT_ADDR: begin
                    nxt_rdata = pin_if.sticky;
                end
                SGIM_SUP_EN_ADDR: begin
                    nxt_rdata = sup_en_ff;
                end
                SGIM_PIN_EN_ADDR: begin
                    nxt_rdata = pin_en_ff;
                end
                // clear registers and unmapped offsets read zero
                default: begin
                    nxt_rdata = SGIM_ZERO;
                end
            endcase
        end
    end

    // ***************************************************
    // request line
    // ***************************************************

    // a set mask bit blocks its source, a clear one lets it through;
    // registered so the pin never glitches, at one cycle of latency
    always_comb begin
        nxt_irq = pend(sup_if.sticky, sup_mask_ff, sup_en_ff) |
                  pend(pin_if.sticky, pin_mask_ff, pin_en_ff);
    end

    // ***************************************************
    // registers
    // ***************************************************

    // every source starts blocked until software opens it
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sup_mask_ff <= SGIM_SUP_MASK_RST;
            pin_mask_ff <= SGIM_PIN_MASK_RST;
            sup_en_ff <= SGIM_SUP_EN_RST;
            pin_en_ff <= SGIM_PIN_EN_RST;
            sup_clr_ff <= SGIM_ZERO;
            pin_clr_ff <= SGIM_ZERO;
            rdata_ff <= SGIM_ZERO;
            irq_ff <= 1'b0;
        end else begin
            sup_mask_ff <= nxt_sup_mask;
            pin_mask_ff <= nxt_pin_mask;
            sup_en_ff <= nxt_sup_en;
            pin_en_ff <= nxt_pin_en;
            sup_clr_ff <= nxt_sup_clr;
            pin_clr_ff <= nxt_pin_clr;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign irq_o = irq_ff;

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // nothing passes a mask, so the line stays low
    property p_mask_blocks;
        ((sup_if.sticky & ~sup_mask_ff) == SGIM_ZERO) &&
        ((pin_if.sticky & ~pin_mask_ff) == SGIM_ZERO) |=> !irq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("request raised with every pending source masked");

    // first edge after release sees all masks set
    property p_reset_masked;
        $fell(reset_i) |-> (sup_mask_ff == SGIM_SUP_IMPL) &&
                           (pin_mask_ff == SGIM_PIN_IMPL);
    endproperty
    a_reset_masked: assert property (p_reset_masked)
        else $error("mask bits not all set after reset");

    // a supply mask write lands, holes dropped, and reads back
    sequence s_sup_wr;
        reg_wr_i && hit(reg_addr_i, SGIM_SUP_MASK_ADDR);
    endsequence
    sequence s_sup_rd;
        reg_rd_i && hit(reg_addr_i, SGIM_SUP_MASK_ADDR);
    endsequence
    property p_sup_layout;
        s_sup_wr ##1 s_sup_rd |=>
            reg_rdata_o == ($past(reg_wdata_i, 2) & SGIM_SUP_IMPL);
    endproperty
    a_sup_layout: assert property (p_sup_layout)
        else $error("supply mask write did not read back with its layout");

    // pin 1 opened: its edge raises the line two cycles on
    sequence s_pin1_edge;
        $rose(pin_event_i[PIN1_EVENT_MASK_BIT]) &&
        !pin_mask_ff[PIN1_EVENT_MASK_BIT] && pin_en_ff[PIN1_EVENT_MASK_BIT];
    endsequence
    sequence s_pin1_open;
        !pin_mask_ff[PIN1_EVENT_MASK_BIT] && pin_en_ff[PIN1_EVENT_MASK_BIT];
    endsequence
    property p_pin1_raise;
        s_pin1_edge ##1 s_pin1_open |=> irq_o;
    endproperty
    a_pin1_raise: assert property (p_pin1_raise)
        else $error("pin 1 event did not reach the request line");

    // pin mask write keeps bits 11..0 only
    property p_pin_layout;
        reg_wr_i && hit(reg_addr_i, SGIM_PIN_MASK_ADDR) |=>
            pin_mask_ff == ($past(reg_wdata_i) & SGIM_PIN_IMPL);
    endproperty
    a_pin_layout: assert property (p_pin_layout)
        else $error("pin mask write not stored as bits 11 to 0");

    // an open pending supply source holds the line next cycle
    property p_raise;
        pend(sup_if.sticky, sup_mask_ff, sup_en_ff) |=> irq_o;
    endproperty
    a_raise: assert property (p_raise)
        else $error("open supply event did not raise the request");

    // unused supply mask bits never read as one
    property p_holes_zero;
        s_sup_rd |=> (reg_rdata_o & ~SGIM_SUP_IMPL) == SGIM_ZERO;
    endproperty
    a_holes_zero: assert property (p_holes_zero)
        else $error("unused supply mask bits read nonzero");

    // a read answer lives one cycle only
    property p_rd_once;
        !reg_rd_i |=> reg_rdata_o == SGIM_ZERO;
    endproperty
    a_rd_once: assert property (p_rd_once)
        else $error("read data stood outside its answer cycle");

    // pin mask reads never show bits above 11
    sequence s_pin_rd;
        reg_rd_i && hit(reg_addr_i, SGIM_PIN_MASK_ADDR);
    endsequence
    property p_pin_holes;
        s_pin_rd |=> (reg_rdata_o & ~SGIM_PIN_IMPL) == SGIM_ZERO;
    endproperty
    a_pin_holes: assert property (p_pin_holes)
        else $error("unused pin mask bits read nonzero");

    // an open pending pin source holds the line next cycle
    property p_pin_raise;
        pend(pin_if.sticky, pin_mask_ff, pin_en_ff) |=> irq_o;
    endproperty
    a_pin_raise: assert property (p_pin_raise)
        else $error("open pin event did not raise the request");

    // supply masks stay blocked until software writes them
    property p_sup_hold;
        !(reg_wr_i && hit(reg_addr_i, SGIM_SUP_MASK_ADDR)) |=> $stable(sup_mask_ff);
    endproperty
    a_sup_hold: assert property (p_sup_hold)
        else $error("supply mask changed without a write");

    // pin masks stay blocked until software writes them
    property p_pin_hold;
        !(reg_wr_i && hit(reg_addr_i, SGIM_PIN_MASK_ADDR)) |=> $stable(pin_mask_ff);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pin mask changed without a write");

endmodule

`default_nettype wire

// ### test/sgim_host_model.sv
// host processor model: drives the register port and watches the interrupt line
`timescale 1ns/100ps
`default_nettype none

module sgim_host_model (
    input wire logic clk_sys_i,
    input wire logic [sgim_pkg::SGIM_DW-1:0] reg_rdata_i,
    input wire logic irq_i,
    output var logic [sgim_pkg::SGIM_AW-1:0] reg_addr_o,
    output var logic [sgim_pkg::SGIM_DW-1:0] reg_wdata_o,
    output var logic reg_wr_o,
    output var logic reg_rd_o
);
    import sgim_pkg::*;

    // ***************************************************
    // idle bus levels
    // ***************************************************
    // strobes low from time zero so nothing is taken during reset
    initial begin
        reg_addr_o = 16'h0000;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // ***************************************************
    // access tasks
    // ***************************************************
    // one-cycle write; address and data flip after release so stale values never match
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // write then read one offset with no idle cycle between the two strobes
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] wd, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= wd;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b1;
        reg_wdata_o <= ~wd;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask

    // one-cycle read; data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        d = reg_rdata_i;
    endtask
endmodule

`default_nettype wire

// ### test/test_sgim_top.sv
// self-checking testbench for the interrupt mask bank
`timescale 1ns/100ps
`default_nettype none

module test_sgim_top;
    import sgim_pkg::*;

    // ***************************************************
    // signals
    // ***************************************************
    logic clk_sys_i = 1'b0; // 100 MHz system clock
    logic reset_i = 1'b1; // async reset, held at start
    logic [15:0] reg_addr; // from host model
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata; // to host model
    logic [15:0] sup_ev = 16'h0000; // live supply sources
    logic [11:0] pin_ev = 12'h000; // live pin sources
    logic irq; // interrupt request
    int num_errors = 0;
    int check_count = 0;
    logic [15:0] v; // read scratch
    // register table: address and reset value
    logic [15:0] reg_a[9] = '{16'h401C, 16'h401D, 16'h4040, 16'h4041, 16'h4042,
        16'h4043, 16'h4044, 16'h4045, 16'h401E};
    logic [15:0] reg_rst[9] = '{16'h038F, 16'h0FFF, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h038F, 16'h0FFF, 16'h0000};
    // writable registers and their implemented bits
    logic [15:0] rw_a[4] = '{16'h401C, 16'h401D, 16'h4044, 16'h4045};
    logic [15:0] rw_m[4] = '{16'h038F, 16'h0FFF, 16'h038F, 16'h0FFF};
    int sup_bits[7] = '{9, 8, 7, 3, 2, 1, 0}; // implemented supply mask bits

    // clock: invert every half period
    always #5 clk_sys_i = ~clk_sys_i;

    // ***************************************************
    // design and host
    // ***************************************************
    sgim_top dut (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata),
        .supply_event_i(sup_ev),
        .pin_event_i(pin_ev),
        .irq_o(irq)
    );

    sgim_host_model host (
        .clk_sys_i(clk_sys_i),
        .reg_rdata_i(reg_rdata),
        .irq_i(irq),
        .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd)
    );

    // ***************************************************
    // helpers
    // ***************************************************
    // compare with case inequality so unknowns never pass
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // irq lags the event by two edges; three leaves margin
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check({15'h0000, host.irq_i}, {15'h0000, exp});
    endtask

    // drive one bank of sources just after an edge
    task automatic drive_ev(input logic is_pin, input logic [15:0] val);
        @(posedge clk_sys_i);
        if (is_pin) begin
            pin_ev <= val[11:0];
        end else begin
            sup_ev <= val;
        end
    endtask

    // unmask one bit only: other sources must stay silent, the chosen one must fire
    task automatic ev_case(input logic is_pin, input int b);
        logic [15:0] impl;
        logic [15:0] one;
        logic [15:0] ma;
        logic [15:0] st;
        impl = is_pin ? SGIM_PIN_IMPL : SGIM_SUP_IMPL;
        one = 16'h0001 << b;
        ma = is_pin ? SGIM_PIN_MASK_ADDR : SGIM_SUP_MASK_ADDR;
        host.wr(ma, impl & ~one);
        drive_ev(is_pin, impl & ~one);
        irq_is(1'b0);
        drive_ev(is_pin, impl);
        irq_is(1'b1);
        host.rd(is_pin ? SGIM_PIN_STAT_ADDR : SGIM_SUP_STAT_ADDR, st);
        check(st, impl);
        host.wr(is_pin ? SGIM_PIN_CLR_ADDR : SGIM_SUP_CLR_ADDR, impl);
        irq_is(1'b0);
        drive_ev(is_pin, 16'h0000);
        host.wr(ma, impl);
    endtask

    // single place where the run ends
    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ***************************************************
    // watchdog
    // ***************************************************
    // tests need well under 1500 cycles; 20 us leaves ample room
    initial begin
        #20000;
        num_errors++;
        conclude();
    end

    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        // reset values, unmapped address reads zero
        for (int i = 0; i < 9; i++) begin
            host.rd(reg_a[i], v);
            check(v, reg_rst[i]);
        end
        $display("test reset values done");
        // unused bits ignore writes, used bits hold both levels
        for (int i = 0; i < 4; i++) begin
            host.wr_rd(rw_a[i], 16'hFFFF, v);
            check(v, rw_m[i]);
            host.wr_rd(rw_a[i], 16'h0000, v);
            check(v, 16'h0000);
            host.wr(rw_a[i], rw_m[i]);
        end
        host.wr(16'h401E, 16'hFFFF);
        host.rd(16'h401E, v);
        check(v, 16'h0000);
        $display("test register access done");
        // every supply mask bit on its own source
        foreach (sup_bits[i]) begin
            ev_case(1'b0, sup_bits[i]);
        end
        $display("test supply events done");
        // pin n masked by bit n-1
        for (int b = 0; b < 12; b++) begin
            ev_case(1'b1, b);
        end
        $display("test pin events done");
        // enable gates the line; a new edge in the clear cycle must survive
        host.wr(SGIM_SUP_MASK_ADDR, 16'h038E);
        host.wr(SGIM_SUP_EN_ADDR, 16'h038E);
        drive_ev(1'b0, 16'h0001);
        irq_is(1'b0);
        host.wr(SGIM_SUP_EN_ADDR, 16'h038F);
        irq_is(1'b1);
        drive_ev(1'b0, 16'h0000);
        host.wr(SGIM_SUP_CLR_ADDR, 16'h0001);
        sup_ev <= 16'h0001;
        host.rd(SGIM_SUP_STAT_ADDR, v);
        check(v, 16'h0001);
        irq_is(1'b1);
        host.wr(SGIM_SUP_CLR_ADDR, 16'h0001);
        irq_is(1'b0);
        drive_ev(1'b0, 16'h0000);
        host.wr(SGIM_SUP_MASK_ADDR, 16'h038F);
        $display("test enable and clear race done");
        // reset in mid-run restores the blocked state
        host.wr(SGIM_SUP_MASK_ADDR, 16'h0000);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        host.rd(SGIM_SUP_MASK_ADDR, v);
        check(v, 16'h038F);
        $display("test second reset done");
        conclude();
    end
endmodule

`default_nettype wire
